/* File: verilog/frs_pkg.sv */
// constants and types for the fault release and slave replacement controller
// ****************************************
// Notes on behaviour
// ****************************************
package frs_pkg;
	localparam int CLK_MHZ = 250;
	localparam int DEBOUNCE_MS = 20;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int ACK_MS = 100;
	localparam int ACK_CYC = ACK_MS * 1000 * CLK_MHZ;
	localparam int FLASH_MS = 250;
	localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;
	localparam int NCIRC = 2;
	localparam int ERR_W = 4;
	localparam logic [ERR_W-1:0] ERR_NONE = 4'h0;
	localparam logic [ERR_W-1:0] ERR_ONE_MISSING = 4'h1;
	localparam logic [ERR_W-1:0] ERR_NOT_ONE = 4'h2;
	localparam logic [ERR_W-1:0] ERR_CODE_BAD = 4'h3;
	localparam logic [ERR_W-1:0] ERR_SWAP_LIVE = 4'h4;
	localparam logic [ERR_W-1:0] ERR_EXT = 4'h5;

	typedef enum logic [5:0] {
		FRS_ST_START = 6'h01,
		FRS_ST_PROT = 6'h02,
		FRS_ST_ERROR = 6'h04,
		FRS_ST_CFG = 6'h08,
		FRS_ST_TEACH = 6'h10,
		FRS_ST_XFER = 6'h20
	} frs_state_t;
endpackage : frs_pkg

/* File: verilog/frs_btn_if.sv */
// carrier between debouncer and controller
`timescale 1ns/100ps
interface frs_btn_if;
	logic press;
	logic level;
	modport src (output press, output level);
	modport dst (input press, input level);
endinterface : frs_btn_if

/* File: verilog/frs_debounce.sv */
// service button debouncer, one pulse per settled press
`timescale 1ns/100ps
module frs_debounce #(
	parameter int DEB_CYC = frs_pkg::DEBOUNCE_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic btn_raw,
	frs_btn_if.src out
);
	typedef struct packed {
		logic stable;
		logic [frs_pkg::CNT_W-1:0] cnt;
		logic press;
	} frs_deb_t;
	frs_deb_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.press = 1'b0;
		if (btn_raw == s_reg.stable) begin
			s_next.cnt = '0;
		end else if (s_reg.cnt >= DEB_CYC[frs_pkg::CNT_W-1:0] - 32'h1) begin
			s_next.cnt = '0;
			s_next.stable = btn_raw;
			s_next.press = btn_raw;
		end else begin
			s_next.cnt = s_reg.cnt + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign out.press = s_reg.press;
	assign out.level = s_reg.stable;

	chk_one_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		s_reg.press |=> !s_reg.press) else $error("press pulse longer than one cycle");
endmodule : frs_debounce

/* File: verilog/frs_ctrl.sv */
// operating state control: fault release, slave replacement, config transfer
`timescale 1ns/100ps
module frs_ctrl #(
	parameter int DEB_CYC = frs_pkg::DEBOUNCE_CYC,
	parameter int ACK_CYC = frs_pkg::ACK_CYC,
	parameter int FLASH_CYC = frs_pkg::FLASH_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic service_btn,
	input wire logic internal_err,
	input wire logic [frs_pkg::NCIRC-1:0] ext_err,
	input wire logic slave_swapped_live,
	input wire logic start_test_ok,
	input wire logic [7:0] missing_count,
	input wire logic code_valid,
	input wire logic code_ok,
	input wire logic others_quiet,
	input wire logic cfg_stored_valid,
	input wire logic xfer_cable,
	input wire logic xfer_done,
	output logic [frs_pkg::NCIRC-1:0] out_enable,
	output logic [frs_pkg::NCIRC-1:0] led_ready,
	output logic [frs_pkg::NCIRC-1:0] led_on,
	output logic [frs_pkg::NCIRC-1:0] led_fault,
	output logic protective_op,
	output logic config_op,
	output logic device_reset,
	output logic xfer_accept,
	output logic [frs_pkg::ERR_W-1:0] err_memory
);
	frs_btn_if btn ();

	frs_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
		.sys_clk(sys_clk),
		.rst(rst),
		.btn_raw(service_btn),
		.out(btn)
	);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		frs_pkg::frs_state_t st;
		logic [frs_pkg::CNT_W-1:0] ack_cnt;
		logic [frs_pkg::CNT_W-1:0] flash_cnt;
		logic flash;
		logic dev_err;
		logic [frs_pkg::NCIRC-1:0] circ_err;
		logic [frs_pkg::ERR_W-1:0] err_mem;
		logic one_missing;
		logic rst_pulse;
	} frs_ctrl_t;
	frs_ctrl_t s_reg, s_next;

	logic any_err;
	assign any_err = internal_err | (|ext_err) | slave_swapped_live;

	always_comb begin
		s_next = s_reg;
		s_next.rst_pulse = 1'b0;
		// free-running flash timebase
		if (s_reg.flash_cnt >= FLASH_CYC[frs_pkg::CNT_W-1:0] - 32'h1) begin
			s_next.flash_cnt = '0;
			s_next.flash = ~s_reg.flash;
		end else begin
			s_next.flash_cnt = s_reg.flash_cnt + 32'h1;
		end
		if (s_reg.ack_cnt != '0) begin
			s_next.ack_cnt = s_reg.ack_cnt - 32'h1;
		end
		if (btn.press) begin
			s_next.ack_cnt = ACK_CYC[frs_pkg::CNT_W-1:0];
		end
		case (s_reg.st)
			frs_pkg::FRS_ST_START: begin
				// outputs stay off until the start test passes
				if (any_err) begin
					s_next.st = frs_pkg::FRS_ST_ERROR;
					s_next.circ_err = ext_err;
					s_next.dev_err = internal_err | slave_swapped_live;
				end else if (start_test_ok) begin
					s_next.st = frs_pkg::FRS_ST_PROT;
				end
			end
			frs_pkg::FRS_ST_PROT: begin
				if (slave_swapped_live) begin
					s_next.st = frs_pkg::FRS_ST_ERROR;
					s_next.dev_err = 1'b1;
					s_next.err_mem = frs_pkg::ERR_SWAP_LIVE;
				end else if (internal_err | (|ext_err)) begin
					s_next.st = frs_pkg::FRS_ST_ERROR;
					s_next.circ_err = ext_err;
					s_next.dev_err = internal_err;
					s_next.err_mem = frs_pkg::ERR_EXT;
				end else if (btn.press) begin
					s_next.st = frs_pkg::FRS_ST_CFG;
					s_next.one_missing = (missing_count == 8'h01);
					s_next.err_mem = (missing_count == 8'h01) ?
						frs_pkg::ERR_ONE_MISSING : frs_pkg::ERR_NOT_ONE;
				end
			end
			frs_pkg::FRS_ST_ERROR: begin
				if (btn.press) begin
					// release the lock and restart through the start test
					s_next.st = frs_pkg::FRS_ST_START;
					s_next.rst_pulse = 1'b1;
					s_next.dev_err = 1'b0;
					s_next.circ_err = '0;
				end
			end
			frs_pkg::FRS_ST_CFG: begin
				if (xfer_cable && !cfg_stored_valid) begin
					s_next.st = frs_pkg::FRS_ST_XFER;
				end else if (btn.press) begin
					s_next.st = frs_pkg::FRS_ST_TEACH;
				end
			end
			frs_pkg::FRS_ST_TEACH: begin
				// a missing-count other than one, or noisy other slaves, fails teaching
				if (code_valid) begin
					if (code_ok && others_quiet && s_reg.one_missing) begin
						s_next.st = frs_pkg::FRS_ST_PROT;
						s_next.err_mem = frs_pkg::ERR_NONE;
					end else begin
						s_next.st = frs_pkg::FRS_ST_CFG;
						s_next.err_mem = frs_pkg::ERR_CODE_BAD;
					end
				end
			end
			frs_pkg::FRS_ST_XFER: begin
				if (xfer_done) begin
					s_next.st = frs_pkg::FRS_ST_START;
					s_next.rst_pulse = 1'b1;
				end
			end
			default: begin
				s_next.st = frs_pkg::FRS_ST_START;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= frs_pkg::FRS_ST_START;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	logic ack_on;
	assign ack_on = (s_reg.ack_cnt != '0);

	always_comb begin
		out_enable = '0;
		if (s_reg.st == frs_pkg::FRS_ST_PROT) begin
			out_enable = '1;
		end
		if (ack_on) begin
			led_ready = '1;
			led_on = '1;
			led_fault = '1;
		end else if (s_reg.dev_err) begin
			led_ready = {frs_pkg::NCIRC{s_reg.flash}};
			led_on = {frs_pkg::NCIRC{s_reg.flash}};
			led_fault = {frs_pkg::NCIRC{s_reg.flash}};
		end else begin
			led_ready = (s_reg.st == frs_pkg::FRS_ST_START) ? '1 : '0;
			led_on = out_enable;
			// affected circuits flash; an unaffected, open circuit shows a steady lamp
			led_fault = (s_reg.circ_err & {frs_pkg::NCIRC{s_reg.flash}}) |
				(~s_reg.circ_err & ~out_enable);
		end
	end

	assign protective_op = (s_reg.st == frs_pkg::FRS_ST_PROT);
	assign config_op = (s_reg.st == frs_pkg::FRS_ST_CFG) | (s_reg.st == frs_pkg::FRS_ST_TEACH);
	assign device_reset = s_reg.rst_pulse;
	assign xfer_accept = (s_reg.st == frs_pkg::FRS_ST_XFER);
	assign err_memory = s_reg.err_mem;

	// ****************************************
	// checks
	// ****************************************
	sequence seq_in_teach;
		s_reg.st == frs_pkg::FRS_ST_TEACH && code_valid;
	endsequence
	sequence seq_pass;
		code_ok && others_quiet && s_reg.one_missing;
	endsequence

	chk_release_reset: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_ERROR && btn.press) |=> device_reset && !protective_op)
		else $error("error release did not reset");
	chk_start_gate: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_START && !start_test_ok) |=> !protective_op)
		else $error("protective without start test");
	chk_ack_lamps: assert property (@(posedge sys_clk) disable iff (rst)
		btn.press |=> (&led_ready && &led_on && &led_fault)[*2])
		else $error("press not acknowledged");
	chk_swap_error: assert property (@(posedge sys_clk) disable iff (rst)
		(protective_op && slave_swapped_live) |=> s_reg.st == frs_pkg::FRS_ST_ERROR)
		else $error("live swap missed");
	chk_missing_record: assert property (@(posedge sys_clk) disable iff (rst)
		(protective_op && !any_err && btn.press) |=>
			err_memory == (($past(missing_count) == 8'h01) ?
			frs_pkg::ERR_ONE_MISSING : frs_pkg::ERR_NOT_ONE))
		else $error("missing check not recorded");
	chk_cfg_outputs_off: assert property (@(posedge sys_clk) disable iff (rst)
		!protective_op |-> out_enable == '0)
		else $error("outputs active outside protective");
	chk_teach_pass: assert property (@(posedge sys_clk) disable iff (rst)
		seq_in_teach ##0 seq_pass |=> protective_op)
		else $error("good code not accepted");
	chk_teach_fail: assert property (@(posedge sys_clk) disable iff (rst)
		seq_in_teach ##0 !others_quiet |=> config_op && !protective_op)
		else $error("slave accepted with others sending");
	chk_xfer_gate: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(xfer_accept) |-> !$past(cfg_stored_valid))
		else $error("transfer over valid config");
	chk_fault_flash: assert property (@(posedge sys_clk) disable iff (rst)
		(protective_op && ext_err[0] && !internal_err && !slave_swapped_live) |=>
			s_reg.circ_err[0])
		else $error("fault not flagged");
	chk_err_entry: assert property (@(posedge sys_clk) disable iff (rst)
		(protective_op && (internal_err || (|ext_err))) |=> s_reg.st == frs_pkg::FRS_ST_ERROR)
		else $error("error did not lock");
	chk_circ_flash: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_ERROR && !s_reg.dev_err && !ack_on && s_reg.circ_err[0])
			|-> led_fault[0] == s_reg.flash)
		else $error("affected fault lamp not flashing");
	chk_err_hold: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_ERROR && !btn.press) |=>
			s_reg.st == frs_pkg::FRS_ST_ERROR)
		else $error("error lock left without press");
	chk_reset_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		device_reset |=> !device_reset)
		else $error("reset pulse longer than one cycle");
	chk_dev_flash: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.dev_err && !ack_on) |-> (led_ready == led_fault && led_on == led_fault))
		else $error("device error lamps not together");
	chk_cfg_entry: assert property (@(posedge sys_clk) disable iff (rst)
		(protective_op && !any_err && btn.press) |=> config_op && out_enable == '0)
		else $error("press did not enter configuration");
	chk_teach_entry: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_CFG && btn.press && !(xfer_cable && !cfg_stored_valid))
			|=> s_reg.st == frs_pkg::FRS_ST_TEACH)
		else $error("second press did not start teaching");
	chk_teach_wait: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_TEACH && !code_valid) |=>
			s_reg.st == frs_pkg::FRS_ST_TEACH)
		else $error("teaching left without a code");
	chk_xfer_block: assert property (@(posedge sys_clk) disable iff (rst)
		(s_reg.st == frs_pkg::FRS_ST_CFG && cfg_stored_valid) |=> !xfer_accept)
		else $error("transfer started over valid config");
endmodule : frs_ctrl

/* File: sim/frs_slave_model.sv */
// behavioural model of the safe slaves on the bus line
`timescale 1ns/100ps
module frs_slave_model #(
	parameter int SLOW_CYC = 6
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic connected,
	input wire logic slow,
	input wire logic code_good,
	input wire logic quiet,
	input wire logic [7:0] missing,
	output logic [7:0] missing_count,
	output logic code_valid,
	output logic code_ok,
	output logic others_quiet
);
	int wait_reg;
	logic junk_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 0;
			junk_reg <= 1'b0;
		end else begin
			junk_reg <= ~junk_reg;
			wait_reg <= connected ? ((wait_reg < SLOW_CYC) ? wait_reg + 1 : wait_reg) : 0;
		end
	end
	// a slow slave just connected needs SLOW_CYC cycles before its code sequence arrives
	assign code_valid = connected && (!slow || wait_reg >= SLOW_CYC);
	// nothing sent: line toggles so a stale value never reads as a good code
	assign code_ok = code_valid ? code_good : junk_reg;
	assign others_quiet = quiet;
	assign missing_count = missing;
endmodule : frs_slave_model

/* File: sim/fault_release_slave_replace_fsm_test.sv */
// self-checking bench for the operating state controller
`timescale 1ns/100ps
module fault_release_slave_replace_fsm_test;
	logic sys_clk, rst, service_btn, internal_err, slave_swapped_live, start_test_ok;
	logic [1:0] ext_err, out_enable, led_ready, led_on, led_fault;
	logic connected, slow, code_good, quiet, cfg_stored_valid, xfer_cable, xfer_done;
	logic [7:0] missing, missing_count;
	logic code_valid, code_ok, others_quiet, protective_op, config_op, device_reset, xfer_accept;
	logic [frs_pkg::ERR_W-1:0] err_memory;
	int fails, num_checks, resets;

	frs_ctrl #(.DEB_CYC(4), .ACK_CYC(8), .FLASH_CYC(4)) i_dut (.sys_clk, .rst, .service_btn,
		.internal_err, .ext_err, .slave_swapped_live, .start_test_ok, .missing_count,
		.code_valid, .code_ok, .others_quiet, .cfg_stored_valid, .xfer_cable, .xfer_done,
		.out_enable, .led_ready, .led_on, .led_fault, .protective_op, .config_op,
		.device_reset, .xfer_accept, .err_memory);
	frs_slave_model i_slaves (.sys_clk, .rst, .connected, .slow, .code_good, .quiet,
		.missing, .missing_count, .code_valid, .code_ok, .others_quiet);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (device_reset === 1'b1) resets++;

	// ****************************************
	// helpers
	// ****************************************
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic chk(logic ok, string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	// held well past the debounce span, then released for 12 cycles
	task automatic press();
		service_btn = 1'b1;
		cyc(10);
		chk(led_ready === 2'h3 && led_on === 2'h3 && led_fault === 2'h3, "ack lamps");
		cyc(12);
		service_btn = 1'b0;
		cyc(12);
	endtask : press
	task automatic reset_dut();
		rst = 1'b1;
		cyc(12);
		rst = 1'b0;
		cyc(3);
	endtask : reset_dut
	task automatic give_verdict();
		if (fails == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_start();
		chk(led_ready === 2'h3 && protective_op === 1'b0 && out_enable === 2'h0, "start");
		start_test_ok = 1'b1;
		cyc(3);
		chk(protective_op === 1'b1 && out_enable === 2'h3, "no protective op");
	endtask : t_start
	task automatic t_error();
		logic seen0, seen1;
		for (int k = 0; k < 3; k++) begin
			internal_err = (k == 0);
			slave_swapped_live = (k == 1);
			ext_err = (k == 2) ? 2'h1 : 2'h0;
			cyc(3);
			chk(protective_op === 1'b0 && out_enable === 2'h0, "no error lock");
			if (k == 1) chk(err_memory === frs_pkg::ERR_SWAP_LIVE, "swap code");
			if (k == 2) chk(err_memory === frs_pkg::ERR_EXT, "external code");
			seen0 = 1'b0;
			seen1 = 1'b0;
			repeat (12) begin
				cyc(1);
				seen0 |= (led_fault[0] === 1'b0);
				seen1 |= (led_fault[0] === 1'b1);
			end
			chk(seen0 && seen1, "fault lamp not flashing");
			internal_err = 1'b0;
			slave_swapped_live = 1'b0;
			ext_err = 2'h0;
			start_test_ok = 1'b0;
			resets = 0;
			press();
			chk(resets === 1 && protective_op === 1'b0, "release");
			start_test_ok = 1'b1;
			cyc(3);
			chk(protective_op === 1'b1, "no restart");
		end
	endtask : t_error
	task automatic t_replace();
		xfer_cable = 1'b0;
		missing = 8'h01;
		service_btn = 1'b1;
		cyc(2);
		service_btn = 1'b0;
		cyc(12);
		chk(config_op === 1'b0, "bounce counted");
		press();
		chk(config_op === 1'b1 && out_enable === 2'h0, "no config op");
		chk(err_memory === frs_pkg::ERR_ONE_MISSING, "missing check");
		connected = 1'b1;
		press();
		chk(protective_op === 1'b1 && err_memory === frs_pkg::ERR_NONE, "teach");
		connected = 1'b0;
	endtask : t_replace
	task automatic t_bad();
		logic [7:0] mis [3] = '{8'h02, 8'h01, 8'h01};
		logic good [3] = '{1'b1, 1'b0, 1'b1};
		logic qui [3] = '{1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 3; i++) begin
			reset_dut();
			missing = mis[i];
			code_good = good[i];
			quiet = qui[i];
			slow = 1'b1;
			press();
			chk(err_memory === ((i == 0) ? frs_pkg::ERR_NOT_ONE : frs_pkg::ERR_ONE_MISSING),
				"first press memory");
			connected = 1'b1;
			press();
			chk(config_op === 1'b1 && protective_op === 1'b0, "bad slave taken");
			chk(err_memory === frs_pkg::ERR_CODE_BAD, "code check");
			connected = 1'b0;
		end
	endtask : t_bad
	task automatic t_xfer();
		xfer_cable = 1'b1;
		cfg_stored_valid = 1'b1;
		cyc(3);
		chk(xfer_accept === 1'b0, "overwrote valid config");
		cfg_stored_valid = 1'b0;
		cyc(2);
		chk(xfer_accept === 1'b1, "transfer refused");
		start_test_ok = 1'b0;
		resets = 0;
		xfer_done = 1'b1;
		cyc(1);
		xfer_done = 1'b0;
		xfer_cable = 1'b0;
		cyc(3);
		chk(resets === 1 && protective_op === 1'b0, "transfer end");
		start_test_ok = 1'b1;
		cyc(3);
		chk(protective_op === 1'b1, "no start after transfer");
	endtask : t_xfer

	initial begin
		{rst, service_btn, internal_err, slave_swapped_live, start_test_ok} = 5'h10;
		{ext_err, connected, slow, code_good, quiet} = 6'h03;
		{cfg_stored_valid, xfer_cable, xfer_done, missing} = 11'h000;
		fails = 0;
		num_checks = 0;
		reset_dut();
		t_start();
		t_error();
		t_replace();
		t_bad();
		t_xfer();
		give_verdict();
	end
	// whole run is some 520 cycles; this span of 25000 cycles is far beyond it
	initial begin
		#100000;
		fails++;
		give_verdict();
	end
endmodule : fault_release_slave_replace_fsm_test
